// *** design/ssp_top.sv ***
`timescale 1ns/100ps
module ssp_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out,
  output logic irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  typedef enum logic [2:0] {TX_IDLE, TX_SHIFT, TX_START, TX_DATA, TX_NINTH, TX_STOP} ssp_tx_state_t;

  logic sm0_q, sm0_d, sm1_q, sm1_d, sm2_q, sm2_d, ren_q, ren_d;
  logic tb8_q, tb8_d, rb8_q, rb8_d, ti_q, ti_d, ri_q, ri_d, fe_q, fe_d;
  logic fe_view_q, fe_view_d, rate_double_q, rate_double_d;
  logic [7:0] div_q, div_d, rx_buf_q, rx_buf_d;
  logic [2:0] irq_st_q, irq_st_d, irq_mask_q, irq_mask_d;
  logic ack_q, err_q;
  logic [31:0] prdata_q;
  logic ack_d, err_d;
  logic [31:0] prdata_d;
  logic xfer, wr, rd, mapped, setup;
  logic [7:0] ctl_view;
  ssp_pkg::ssp_mode_t mode;
  logic [8:0] period;
  logic tick;
  logic rx_done;
  ssp_pkg::ssp_rx_frame_t rx_frame;
  logic rx_ok, fe_set, ri_set, ti_set, m0_ri_set;
  ssp_tx_state_t st_q, st_d;
  logic [7:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] bit_q, bit_d;
  logic phase_q, phase_d, m0_rx_q, m0_rx_d;
  logic txd_q, txd_d, rxo_q, rxo_d, oe_q, oe_d;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign setup = psel & ~penable;
  assign xfer = psel & penable & ack_q;
  assign wr = xfer & pwrite & pstrb[0];
  assign rd = xfer & ~pwrite;
  assign mode = ssp_pkg::ssp_mode_t'({sm0_q, sm1_q});
  assign ctl_view = {fe_view_q ? fe_q : sm0_q, sm1_q, sm2_q, ren_q, tb8_q, rb8_q, ti_q, ri_q};

  always_comb begin
    mapped = ssp_pkg::ssp_hit(paddr, ssp_pkg::IDX_CONTROL) |
             ssp_pkg::ssp_hit(paddr, ssp_pkg::IDX_DATA) |
             ssp_pkg::ssp_hit(paddr, ssp_pkg::IDX_POWER) |
             ssp_pkg::ssp_hit(paddr, ssp_pkg::IDX_DIVISOR) |
             ssp_pkg::ssp_hit(paddr, ssp_pkg::IDX_IRQ_STATUS) |
             ssp_pkg::ssp_hit(paddr, ssp_pkg::IDX_IRQ_MASK);
    prdata_d = prdata_q;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      if (ssp_pkg::ssp_hit(paddr, ssp_pkg::IDX_CONTROL)) begin
        prdata_d[7:0] = ctl_view;
      end
      if (ssp_pkg::ssp_hit(paddr, ssp_pkg::IDX_DATA)) begin
        prdata_d[7:0] = rx_buf_q;
      end
      if (ssp_pkg::ssp_hit(paddr, ssp_pkg::IDX_POWER)) begin
        prdata_d[ssp_pkg::POW_FE_VIEW] = fe_view_q;
        prdata_d[ssp_pkg::POW_RATE_DOUBLE] = rate_double_q;
      end
      if (ssp_pkg::ssp_hit(paddr, ssp_pkg::IDX_DIVISOR)) begin
        prdata_d[7:0] = div_q;
      end
      if (ssp_pkg::ssp_hit(paddr, ssp_pkg::IDX_IRQ_STATUS)) begin
        prdata_d[2:0] = irq_st_q;
      end
      if (ssp_pkg::ssp_hit(paddr, ssp_pkg::IDX_IRQ_MASK)) begin
        prdata_d[2:0] = irq_mask_q;
      end
    end
    ack_d = setup;
    err_d = setup & ~mapped;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      err_q <= err_d;
      prdata_q <= prdata_d;
    end
  end

  assign pready = ack_q;
  assign pslverr = err_q;
  assign prdata = prdata_q;

  // ----------------------------------------
  // Rate source and receiver
  // ----------------------------------------
  always_comb begin
    case (mode)
      ssp_pkg::SSP_MODE_SHIFT: begin
        period = sm2_q ? ssp_pkg::SHIFT_HALF_FAST : ssp_pkg::SHIFT_HALF_SLOW;
      end
      ssp_pkg::SSP_MODE_FIXED11: begin
        period = rate_double_q ? ssp_pkg::FIXED_TICK_FAST : ssp_pkg::FIXED_TICK_SLOW;
      end
      default: period = {1'b0, div_q} + 9'h001;
    endcase
  end

  ssp_baud u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .period(period),
    .tick(tick)
  );

  ssp_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .enable(ren_q & (mode != ssp_pkg::SSP_MODE_SHIFT)),
    .tick(tick),
    .eleven(sm0_q),
    .rxd(rxd_in),
    .done(rx_done),
    .frame(rx_frame)
  );

  // ----------------------------------------
  // Control and status registers
  // ----------------------------------------
  always_comb begin
    if (mode == ssp_pkg::SSP_MODE_ASYNC10) begin
      rx_ok = ~sm2_q | rx_frame.stop;
    end else begin
      rx_ok = ~sm2_q | rx_frame.ninth;
    end
    fe_set = rx_done & ~rx_frame.stop;
    ri_set = (rx_done & rx_ok & ~ri_q) | m0_ri_set;
    sm0_d = sm0_q;
    sm1_d = sm1_q;
    sm2_d = sm2_q;
    ren_d = ren_q;
    tb8_d = tb8_q;
    rb8_d = rb8_q;
    ti_d = ti_q;
    ri_d = ri_q;
    fe_d = fe_q;
    fe_view_d = fe_view_q;
    rate_double_d = rate_double_q;
    div_d = div_q;
    rx_buf_d = rx_buf_q;
    irq_mask_d = irq_mask_q;
    irq_st_d = irq_st_q;
    if (wr && ssp_pkg::ssp_hit(paddr, ssp_pkg::IDX_CONTROL)) begin
      if (fe_view_q) begin
        fe_d = fe_q & pwdata[ssp_pkg::CTL_SM0_FE];
      end else begin
        sm0_d = pwdata[ssp_pkg::CTL_SM0_FE];
      end
      sm1_d = pwdata[ssp_pkg::CTL_SM1];
      sm2_d = pwdata[ssp_pkg::CTL_SM2];
      ren_d = pwdata[ssp_pkg::CTL_REN];
      tb8_d = pwdata[ssp_pkg::CTL_TB8];
      rb8_d = pwdata[ssp_pkg::CTL_RB8];
      ti_d = pwdata[ssp_pkg::CTL_TI];
      ri_d = pwdata[ssp_pkg::CTL_RI];
    end
    if (wr && ssp_pkg::ssp_hit(paddr, ssp_pkg::IDX_POWER)) begin
      fe_view_d = pwdata[ssp_pkg::POW_FE_VIEW];
      rate_double_d = pwdata[ssp_pkg::POW_RATE_DOUBLE];
    end
    if (wr && ssp_pkg::ssp_hit(paddr, ssp_pkg::IDX_DIVISOR)) begin
      div_d = pwdata[7:0];
    end
    if (wr && ssp_pkg::ssp_hit(paddr, ssp_pkg::IDX_IRQ_MASK)) begin
      irq_mask_d = pwdata[2:0];
    end
    if (rd && ssp_pkg::ssp_hit(paddr, ssp_pkg::IDX_IRQ_STATUS)) begin
      irq_st_d = irq_st_q & ~prdata_q[2:0];
    end
    // Hardware events win over a software clear in the same cycle
    if (fe_set) begin
      fe_d = 1'b1;
    end
    if (ti_set) begin
      ti_d = 1'b1;
    end
    if (m0_ri_set) begin
      rx_buf_d = sh_q;
    end else if (ri_set) begin
      rx_buf_d = rx_frame.data;
      rb8_d = (mode == ssp_pkg::SSP_MODE_ASYNC10) ? rx_frame.stop : rx_frame.ninth;
    end
    if (ri_set) begin
      ri_d = 1'b1;
    end
    irq_st_d = irq_st_d | {fe_set, ti_set, ri_set};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sm0_q <= 1'b0;
      sm1_q <= 1'b0;
      sm2_q <= 1'b0;
      ren_q <= 1'b0;
      tb8_q <= 1'b0;
      rb8_q <= 1'b0;
      ti_q <= 1'b0;
      ri_q <= 1'b0;
      fe_q <= 1'b0;
      fe_view_q <= 1'b0;
      rate_double_q <= 1'b0;
      div_q <= ssp_pkg::DIVISOR_RST;
      rx_buf_q <= 8'h00;
      irq_st_q <= 3'h0;
      irq_mask_q <= ssp_pkg::IRQ_MASK_RST;
    end else begin
      sm0_q <= sm0_d;
      sm1_q <= sm1_d;
      sm2_q <= sm2_d;
      ren_q <= ren_d;
      tb8_q <= tb8_d;
      rb8_q <= rb8_d;
      ti_q <= ti_d;
      ri_q <= ri_d;
      fe_q <= fe_d;
      fe_view_q <= fe_view_d;
      rate_double_q <= rate_double_d;
      div_q <= div_d;
      rx_buf_q <= rx_buf_d;
      irq_st_q <= irq_st_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  assign irq = |(irq_st_q & irq_mask_q);

  // ----------------------------------------
  // Transmit engine and shift-mode engine
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    phase_d = phase_q;
    m0_rx_d = m0_rx_q;
    txd_d = txd_q;
    rxo_d = rxo_q;
    oe_d = oe_q;
    ti_set = 1'b0;
    m0_ri_set = 1'b0;
    case (st_q)
      TX_IDLE: begin
        txd_d = 1'b1;
        oe_d = 1'b0;
        cnt_d = 4'h0;
        bit_d = 3'h0;
        phase_d = 1'b0;
        if (wr && ssp_pkg::ssp_hit(paddr, ssp_pkg::IDX_DATA)) begin
          sh_d = pwdata[7:0];
          m0_rx_d = 1'b0;
          if (mode == ssp_pkg::SSP_MODE_SHIFT) begin
            st_d = TX_SHIFT;
            rxo_d = pwdata[0];
            oe_d = 1'b1;
          end else begin
            st_d = TX_START;
            txd_d = 1'b0;
          end
        end else if (mode == ssp_pkg::SSP_MODE_SHIFT && ren_q && !ri_q) begin
          st_d = TX_SHIFT;
          m0_rx_d = 1'b1;
        end
      end
      TX_SHIFT: begin
        // First tick aligns the low phase to the free-running rate source
        if (cnt_q == 4'h0) begin
          if (tick) begin
            cnt_d = 4'h1;
            txd_d = 1'b0;
          end
        end else if (tick && !phase_q) begin
          phase_d = 1'b1;
          txd_d = 1'b1;
          if (m0_rx_q) begin
            sh_d = {rxd_in, sh_q[7:1]};
          end
        end else if (tick) begin
          if (bit_q == ssp_pkg::BIT_LAST) begin
            st_d = TX_IDLE;
            oe_d = 1'b0;
            ti_set = ~m0_rx_q;
            m0_ri_set = m0_rx_q;
          end else begin
            bit_d = bit_q + 3'h1;
            phase_d = 1'b0;
            txd_d = 1'b0;
            if (!m0_rx_q) begin
              sh_d = {1'b0, sh_q[7:1]};
              rxo_d = sh_q[1];
            end
          end
        end
      end
      default: begin
        if (tick) begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == ssp_pkg::OVS_LAST) begin
            case (st_q)
              TX_START: begin
                st_d = TX_DATA;
                txd_d = sh_q[0];
              end
              TX_DATA: begin
                sh_d = {1'b0, sh_q[7:1]};
                bit_d = bit_q + 3'h1;
                txd_d = sh_q[1];
                if (bit_q == ssp_pkg::BIT_LAST) begin
                  if (sm0_q) begin
                    st_d = TX_NINTH;
                    txd_d = tb8_q;
                  end else begin
                    st_d = TX_STOP;
                    txd_d = 1'b1;
                    ti_set = 1'b1;
                  end
                end
              end
              TX_NINTH: begin
                st_d = TX_STOP;
                txd_d = 1'b1;
                ti_set = 1'b1;
              end
              default: begin
                st_d = TX_IDLE;
                txd_d = 1'b1;
              end
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= TX_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      bit_q <= 3'h0;
      phase_q <= 1'b0;
      m0_rx_q <= 1'b0;
      txd_q <= 1'b1;
      rxo_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      phase_q <= phase_d;
      m0_rx_q <= m0_rx_d;
      txd_q <= txd_d;
      rxo_q <= rxo_d;
      oe_q <= oe_d;
    end
  end

  assign txd_out = txd_q;
  assign rxd_out = rxo_q;
  assign rxd_oe = oe_q;

endmodule // ssp_top

// *** design/ssp_pkg.sv ***
package ssp_pkg;

  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] IDX_CONTROL = 8'hC0;
  localparam logic [7:0] IDX_DATA = 8'hC1;
  localparam logic [7:0] IDX_POWER = 8'hC4;
  localparam logic [7:0] IDX_DIVISOR = 8'hC5;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hC6;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hC7;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned CTL_SM0_FE = 7;
  localparam int unsigned CTL_SM1 = 6;
  localparam int unsigned CTL_SM2 = 5;
  localparam int unsigned CTL_REN = 4;
  localparam int unsigned CTL_TB8 = 3;
  localparam int unsigned CTL_RB8 = 2;
  localparam int unsigned CTL_TI = 1;
  localparam int unsigned CTL_RI = 0;
  localparam int unsigned POW_FE_VIEW = 7;
  localparam int unsigned POW_RATE_DOUBLE = 0;
  localparam int unsigned IRQ_RX = 0;
  localparam int unsigned IRQ_TX = 1;
  localparam int unsigned IRQ_FE = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] DIVISOR_RST = 8'h0F;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------
  localparam logic [8:0] SHIFT_HALF_SLOW = 9'h006;
  localparam logic [8:0] SHIFT_HALF_FAST = 9'h002;
  localparam logic [8:0] FIXED_TICK_SLOW = 9'h004;
  localparam logic [8:0] FIXED_TICK_FAST = 9'h002;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [1:0] {
    SSP_MODE_SHIFT,
    SSP_MODE_ASYNC10,
    SSP_MODE_FIXED11,
    SSP_MODE_VAR11
  } ssp_mode_t;

  typedef struct packed {
    logic [7:0] data;
    logic ninth;
    logic stop;
  } ssp_rx_frame_t;

  function automatic logic ssp_hit(input logic [11:0] addr, input logic [7:0] idx);
    ssp_hit = (addr == {2'h0, idx, 2'h0});
  endfunction

endpackage

// *** design/ssp_baud.sv ***
`timescale 1ns/100ps
module ssp_baud (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [8:0] period,
  output logic tick
);

  logic [8:0] cnt_q;
  logic [8:0] cnt_d;

  always_comb begin
    tick = (cnt_q >= (period - 9'h001));
    cnt_d = tick ? 9'h000 : cnt_q + 9'h001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 9'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule // ssp_baud

// *** design/ssp_rx.sv ***
`timescale 1ns/100ps
module ssp_rx (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic tick,
  input wire logic eleven,
  input wire logic rxd,
  output logic done,
  output ssp_pkg::ssp_rx_frame_t frame
);

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} ssp_rx_state_t;

  ssp_rx_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] bit_q, bit_d;
  ssp_pkg::ssp_rx_frame_t fr_q, fr_d;
  logic done_q, done_d;

  assign done = done_q;
  assign frame = fr_q;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    fr_d = fr_q;
    done_d = 1'b0;
    if (!enable) begin
      st_d = RX_IDLE;
    end else if (tick) begin
      cnt_d = cnt_q + 4'h1;
      case (st_q)
        RX_IDLE: begin
          cnt_d = 4'h0;
          if (!rxd) begin
            st_d = RX_START;
          end
        end
        RX_START: begin
          if (cnt_q == ssp_pkg::OVS_MID) begin
            cnt_d = 4'h0;
            bit_d = 3'h0;
            st_d = rxd ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (cnt_q == ssp_pkg::OVS_LAST) begin
            fr_d.data = {rxd, fr_q.data[7:1]};
            bit_d = bit_q + 3'h1;
            if (bit_q == ssp_pkg::BIT_LAST) begin
              st_d = eleven ? RX_NINTH : RX_STOP;
            end
          end
        end
        RX_NINTH: begin
          if (cnt_q == ssp_pkg::OVS_LAST) begin
            fr_d.ninth = rxd;
            st_d = RX_STOP;
          end
        end
        RX_STOP: begin
          // Frame reported at the middle of the stop bit
          if (cnt_q == ssp_pkg::OVS_LAST) begin
            fr_d.stop = rxd;
            done_d = 1'b1;
            st_d = RX_IDLE;
          end
        end
        default: st_d = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= RX_IDLE;
      cnt_q <= 4'h0;
      bit_q <= 3'h0;
      fr_q <= '0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      fr_q <= fr_d;
      done_q <= done_d;
    end
  end

endmodule // ssp_rx

// *** test/ssp_asserts.sv ***
`timescale 1ns/100ps
module ssp_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  input wire logic txd_out
);
  logic mapped;
  assign mapped = paddr inside {12'h300, 12'h304, 12'h310, 12'h314, 12'h318, 12'h31C};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence xfer_s;
    setup_s ##1 penable && pready;
  endsequence
  a_ready_after_setup: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_has_setup: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  a_read_upper_zero: assert property (xfer_s |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_err_unmapped: assert property (setup_s and !mapped |=> pslverr)
    else $error("unmapped access without error");
  a_err_mapped: assert property (setup_s and mapped |=> !pslverr)
    else $error("mapped access flagged");
  a_txd_low_min: assert property ($fell(txd_out) |=> !txd_out)
    else $error("serial out low too short");
  a_txd_high_min: assert property ($rose(txd_out) |=> txd_out)
    else $error("serial out high too short");
  a_shift_data_low: assert property (rxd_oe && $past(rxd_oe) && $changed(rxd_out) |-> !txd_out)
    else $error("shift data changed with clock high");
endmodule // ssp_asserts
bind ssp_top ssp_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd_out(rxd_out),
  .rxd_oe(rxd_oe), .txd_out(txd_out));

// *** test/ssp_remote.sv ***
`timescale 1ns/100ps
module ssp_remote (
  input wire logic pclk,
  input wire logic txd,
  output logic line_q
);
  logic [10:0] got_q;
  initial line_q = 1'h1;
  // Start bit, then nb bits LSB first, each bc clocks; line idles high
  task automatic send(input logic [10:0] f, input int nb, input int bc);
    line_q <= 1'h0;
    repeat (bc) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      line_q <= f[i];
      repeat (bc) @(posedge pclk);
    end
    line_q <= 1'h1;
  endtask
  // Samples each bit in its middle
  task automatic grab(input int nb, input int bc);
    got_q = 11'h000;
    do @(posedge pclk); while (txd !== 1'h0);
    repeat (bc / 2) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      repeat (bc) @(posedge pclk);
      got_q[i] = txd;
    end
  endtask
endmodule // ssp_remote

// *** test/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  typedef struct {
    logic wr;
    logic [11:0] a;
    logic [7:0] d;
    logic [7:0] x;
    logic e;
  } ssp_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd_out, rxd_oe, txd_out, irq;
  logic line, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] pstrb;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;
  ssp_row_t rows[14] = '{
    '{1'h0, 12'h300, 8'h00, 8'h00, 1'h0}, '{1'h0, 12'h304, 8'h00, 8'h00, 1'h0},
    '{1'h0, 12'h310, 8'h00, 8'h00, 1'h0}, '{1'h0, 12'h314, 8'h00, ssp_pkg::DIVISOR_RST, 1'h0},
    '{1'h0, 12'h318, 8'h00, 8'h00, 1'h0}, '{1'h0, 12'h31C, 8'h00, 8'h00, 1'h0},
    '{1'h1, 12'h308, 8'h55, 8'h00, 1'h1}, '{1'h0, 12'h308, 8'h00, 8'h00, 1'h1},
    '{1'h1, 12'h314, 8'h00, 8'h00, 1'h0}, '{1'h0, 12'h314, 8'h00, 8'h00, 1'h0},
    '{1'h1, 12'h31C, 8'h07, 8'h00, 1'h0}, '{1'h0, 12'h31C, 8'h00, 8'h07, 1'h0},
    '{1'h1, 12'h300, 8'h50, 8'h00, 1'h0}, '{1'h0, 12'h300, 8'h00, 8'h50, 1'h0}};
  ssp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_in(rxd_oe ? rxd_out : line), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd_out(txd_out), .irq(irq));
  ssp_remote i_rem (.pclk(pclk), .txd(txd_out), .line_q(line));
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      summarize();
    end
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    apb(1'h0, a, 8'h00);
    chk($sformatf("reg %h", a), {24'h000000, x}, rv);
  endtask
  task automatic irqc(input logic x);
    @(negedge pclk);
    chk("irq", x, irq);
  endtask
  task automatic tx(input logic [7:0] d, input int nb, input int bc, input logic [10:0] x);
    fork
      wr(12'h304, d);
      i_rem.grab(nb, bc);
    join
    chk("frame", x, i_rem.got_q);
    repeat (bc) @(posedge pclk);
  endtask
  task automatic rx(input logic [10:0] f, input int nb, input logic [7:0] c);
    i_rem.send(f, nb, 16);
    repeat (4) @(posedge pclk);
    rd(12'h300, c);
  endtask
  task automatic half(input logic [7:0] c, input int x);
    wr(12'h300, c);
    wr(12'h304, 8'h96);
    n = 0;
    @(negedge pclk);
    while (txd_out !== 1'h0) @(negedge pclk);
    while (txd_out === 1'h0) begin
      n++;
      @(negedge pclk);
    end
    chk("half", x, n);
    chk("oe", 1, rxd_oe);
    repeat (150) @(posedge pclk);
    apb(1'h0, 12'h300, 8'h00);
    chk("ti", 1, rv[1]);
  endtask
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk("row data", {24'h000000, rows[i].x}, rv);
      chk("row error", rows[i].e, ev);
    end
    tx(8'h55, 9, 16, 11'h155);
    rd(12'h300, 8'h52);
    irqc(1'h1);
    rd(12'h318, 8'h02);
    irqc(1'h0);
    wr(12'h300, 8'h50);
    rx(11'h1A3, 9, 8'h55);
    rd(12'h304, 8'hA3);
    wr(12'h31C, 8'h00);
    irqc(1'h0);
    wr(12'h31C, 8'h07);
    irqc(1'h1);
    rd(12'h318, 8'h01);
    irqc(1'h0);
    wr(12'h300, 8'h44);
    rx(11'h13C, 9, 8'h44);
    rd(12'h304, 8'hA3);
    wr(12'h300, 8'h74);
    rx(11'h05A, 9, 8'h74);
    rx(11'h1C5, 9, 8'h75);
    wr(12'h310, 8'h80);
    rd(12'h300, 8'hF5);
    rd(12'h318, 8'h05);
    wr(12'h300, 8'h74);
    rd(12'h300, 8'h74);
    wr(12'h310, 8'h00);
    wr(12'h300, 8'hFC);
    tx(8'hC3, 10, 16, 11'h3C3);
    rd(12'h300, 8'hFE);
    wr(12'h300, 8'hDC);
    rx(11'h211, 10, 8'hD9);
    wr(12'h300, 8'hF8);
    rx(11'h211, 10, 8'hF8);
    rx(11'h322, 10, 8'hFD);
    rd(12'h304, 8'h22);
    wr(12'h310, 8'h01);
    wr(12'h300, 8'h90);
    tx(8'h0F, 10, 32, 11'h20F);
    wr(12'h310, 8'h00);
    tx(8'hF0, 10, 64, 11'h2F0);
    half(8'h00, 6);
    half(8'h20, 2);
    wr(12'h300, 8'h30);
    repeat (80) @(posedge pclk);
    rd(12'h300, 8'h31);
    rd(12'h304, 8'hFF);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    irqc(1'h0);
    chk("txd", 1, txd_out);
    @(posedge pclk);
    presetn <= 1'h1;
    rd(12'h314, ssp_pkg::DIVISOR_RST);
    summarize();
  end
endmodule // tb_top
